/* File: hdl/edge_irq_pkg.sv */
// edge_irq_pkg: constants for the low edge-interrupt selection block.
// assumes one 200 MHz core clock and a decoded register port in front.
// Operation
// [RULE1] 24-bit RW select register, offset 22h, zero reset
// [RULE2] two bits per input, input n at 2n+1:2n
// [RULE3] field 0h: never raise an interrupt
// [RULE4] field 1h: interrupt on rise above threshold
// [RULE5] field 2h: interrupt on fall below threshold
// [RULE6] field 3h: interrupt on both edges
// [RULE7] inputs 8-11 use group 8-11 threshold
// [RULE8] inputs 4-7 use group 4-7 threshold
// [RULE9] inputs 0-3 use group 0-3 threshold
// [RULE10] edges follow current 2-bit group threshold field
// [RULE11] compare new sample with previous sample only
// [RULE12] read returns last written value, no side effects
package edge_irq_pkg;
   localparam int unsigned addr_width = 6;
   localparam int unsigned data_width = 24;
   localparam int unsigned num_inputs = 12;
   localparam int unsigned field_width = 2;
   localparam int unsigned group_size = 4;
   localparam int unsigned num_groups = 3;
   localparam logic [5:0] select_low_offset = 6'h22;
   localparam logic [23:0] select_low_reset = 24'h000000;
   localparam logic [23:0] unmapped_read_value = 24'h000000;
   localparam logic [1:0] edge_sel_none = 2'h0;
   localparam logic [1:0] edge_sel_rise = 2'h1;
   localparam logic [1:0] edge_sel_fall = 2'h2;
   localparam logic [1:0] edge_sel_both = 2'h3;
   localparam logic [1:0] threshold_reset = 2'h0;
   localparam int unsigned read_latency = 1;
   localparam int unsigned event_latency = 1;
endpackage : edge_irq_pkg

/* File: hdl/edge_select_cell.sv */
// edge_select_cell: edge detector and edge selection for one input.
// assumes sample strobe and comparator result come from core_clk logic.
module edge_select_cell
   import edge_irq_pkg::*;
(
   input wire logic core_clk, // core clock
   input wire logic reset, // synchronous, active high
   input wire logic [1:0] sel, // edge selection field
   input wire logic sample_strobe, // new comparator sample present
   input wire logic above, // comparator result, 1 = above threshold
   input wire logic rebase, // threshold of the group changed
   output logic fire // combinational event for this sample
);
   logic prev_r;
   logic prev_nxt;
   logic primed_r;
   logic primed_nxt;
   logic rise;
   logic fall;

   // edge terms only exist between two real samples
   always_comb
   begin
      // a sample in the retune cycle only becomes the new baseline
      rise = sample_strobe && primed_r && !rebase // [RULE10]
         && !prev_r && above; // [RULE11]
      fall = sample_strobe && primed_r && !rebase // [RULE10]
         && prev_r && !above; // [RULE11]
      case (sel)
         edge_sel_none: fire = 1'b0; // [RULE3]
         edge_sel_rise: fire = rise; // [RULE4]
         edge_sel_fall: fire = fall; // [RULE5]
         edge_sel_both: fire = rise || fall; // [RULE6]
         default: fire = 1'b0;
      endcase
   end

   // a threshold change drops the old baseline, so the new level
   // is learnt first and no false edge comes out of the retune
   always_comb
   begin
      prev_nxt = prev_r;
      primed_nxt = primed_r;
      if (sample_strobe)
      begin
         prev_nxt = above; // [RULE11]
         primed_nxt = 1'b1;
      end
      if (rebase)
      begin
         primed_nxt = sample_strobe; // [RULE10]
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         prev_r <= 1'b0;
         primed_r <= 1'b0;
      end
      else
      begin
         prev_r <= prev_nxt;
         primed_r <= primed_nxt;
      end
   end

   property p_none_silent;
      @(posedge core_clk) disable iff (reset)
      (sel == edge_sel_none) |-> !fire;
   endproperty
   a_none_silent: assert property (p_none_silent) // [RULE3]
      else $error("edge fired with selection none");

   property p_rise_only;
      @(posedge core_clk) disable iff (reset)
      (sel == edge_sel_rise && fire) |-> (above && !prev_r);
   endproperty
   a_rise_only: assert property (p_rise_only) // [RULE4]
      else $error("rise selection fired without a rising edge");

   property p_fall_only;
      @(posedge core_clk) disable iff (reset)
      (sel == edge_sel_fall && fire) |-> (!above && prev_r);
   endproperty
   a_fall_only: assert property (p_fall_only) // [RULE5]
      else $error("fall selection fired without a falling edge");

   property p_both_edges;
      @(posedge core_clk) disable iff (reset)
      (sel == edge_sel_both && sample_strobe && primed_r && !rebase
         && (above != prev_r)) |-> fire;
   endproperty
   a_both_edges: assert property (p_both_edges) // [RULE6]
      else $error("both selection missed a transition");

   property p_sampled_only;
      @(posedge core_clk) disable iff (reset)
      fire |-> (sample_strobe && primed_r);
   endproperty
   a_sampled_only: assert property (p_sampled_only) // [RULE11]
      else $error("edge fired on an input that was not sampled");

   property p_rebase_quiet;
      @(posedge core_clk) disable iff (reset)
      rebase |-> !fire;
   endproperty
   a_rebase_quiet: assert property (p_rebase_quiet) // [RULE10]
      else $error("edge fired in the cycle of a threshold change");
endmodule : edge_select_cell

/* File: hdl/edge_irq_select_low.sv */
// edge_irq_select_low: selection register for inputs 0-11 and the
// per-input edge filters that turn comparator crossings into events.
// assumes the serial front end hands over decoded register accesses,
// and that the comparator sequencer and the threshold register run on
// core_clk, so none of those inputs needs a synchroniser.
module edge_irq_select_low
   import edge_irq_pkg::*;
#(
   parameter int unsigned inputs = num_inputs // switch inputs handled
)
(
   input wire logic core_clk, // core clock, 200 MHz
   input wire logic reset, // synchronous, active high
   input wire logic [5:0] reg_addr, // register offset of access
   input wire logic reg_wr, // write strobe, one cycle
   input wire logic [23:0] reg_wdata, // write data
   input wire logic reg_rd, // read strobe, one cycle
   output logic [23:0] reg_rdata, // read data, valid with reg_rvalid
   output logic reg_rvalid, // read answer pulse
   input wire logic [1:0] threshold_group_0_to_3, // group 0-3 level
   input wire logic [1:0] threshold_group_4_to_7, // group 4-7 level
   input wire logic [1:0] threshold_group_8_to_11, // group 8-11 level
   input wire logic [11:0] sample_strobe, // per-input sample taken
   input wire logic [11:0] comp_above, // per-input comparator result
   output logic [23:0] input_threshold_sel, // level used per input
   output logic [11:0] edge_irq_event, // selected edge seen, pulse
   output logic [23:0] edge_irq_select_inputs_low // current selection
);
   logic [23:0] select_r;
   logic [23:0] select_nxt;
   logic [23:0] rdata_r;
   logic [23:0] rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic [5:0] group_thr_r;
   logic [5:0] group_thr_nxt;
   logic [5:0] group_thr_now;
   logic [2:0] group_changed;
   logic [23:0] thr_sel_r;
   logic [23:0] thr_sel_nxt;
   logic [11:0] event_r;
   logic [11:0] event_nxt;
   logic [11:0] fire;
   logic hit;

   assign hit = (reg_addr == select_low_offset);
   assign group_thr_now = {threshold_group_8_to_11,
                           threshold_group_4_to_7,
                           threshold_group_0_to_3};

   // register write path; only the selection register is mapped here,
   // writes to any other offset belong to neighbouring blocks
   always_comb
   begin
      select_nxt = select_r;
      if (reg_wr && hit)
      begin
         select_nxt = reg_wdata; // [RULE1]
      end
   end

   // read path: value before a same-cycle write, no side effects
   always_comb
   begin
      rdata_nxt = rdata_r;
      rvalid_nxt = 1'b0;
      if (reg_rd)
      begin
         rvalid_nxt = 1'b1;
         if (hit)
         begin
            rdata_nxt = select_r; // [RULE12]
         end
         else
         begin
            rdata_nxt = unmapped_read_value;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         select_r <= select_low_reset; // [RULE1]
         rdata_r <= unmapped_read_value;
         rvalid_r <= 1'b0;
      end
      else
      begin
         select_r <= select_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // group threshold tracking; a change restarts that group's baselines
   always_comb
   begin
      group_thr_nxt = group_thr_now;
      for (int g = 0; g < num_groups; g++)
      begin
         group_changed[g] = (group_thr_now[g*2 +: 2]
                             != group_thr_r[g*2 +: 2]); // [RULE10]
      end
   end

   // each input gets its group's change flag and its own selection field
   genvar i;
   generate
      for (i = 0; i < inputs; i++)
      begin : g_input
         localparam int unsigned grp = i / group_size; // group of input
         edge_select_cell u_cell (
            .core_clk(core_clk),
            .reset(reset),
            .sel(select_r[i*field_width +: field_width]), // [RULE2]
            .sample_strobe(sample_strobe[i]),
            .above(comp_above[i]),
            .rebase(group_changed[grp]), // [RULE7] [RULE8] [RULE9]
            .fire(fire[i])
         );
      end
   endgenerate

   // one process for the per-input threshold view, so no vector is
   // written by several processes
   always_comb
   begin
      for (int k = 0; k < num_inputs; k++) // [RULE7] [RULE8] [RULE9]
      begin
         thr_sel_nxt[k*2 +: 2] = group_thr_now[(k / group_size)*2 +: 2];
      end
      event_nxt = fire;
   end

   // outputs all come from flops; events last exactly one cycle
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         group_thr_r <= {num_groups{threshold_reset}};
         thr_sel_r <= {num_inputs{threshold_reset}};
         event_r <= 12'h000;
      end
      else
      begin
         group_thr_r <= group_thr_nxt;
         thr_sel_r <= thr_sel_nxt;
         event_r <= event_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign reg_rvalid = rvalid_r;
   assign input_threshold_sel = thr_sel_r;
   assign edge_irq_event = event_r;
   assign edge_irq_select_inputs_low = select_r;

   property p_reset_zero;
      @(posedge core_clk)
      reset |=> (select_r == select_low_reset && event_r == 12'h000);
   endproperty
   a_reset_zero: assert property (p_reset_zero) // [RULE1]
      else $error("selection or events not clear after reset");

   property p_write_store;
      @(posedge core_clk) disable iff (reset)
      (reg_wr && hit) |=> (select_r == $past(reg_wdata));
   endproperty
   a_write_store: assert property (p_write_store) // [RULE1]
      else $error("write to selection register not stored");

   property p_read_back;
      @(posedge core_clk) disable iff (reset)
      (reg_rd && hit) |=> (reg_rvalid && reg_rdata == $past(select_r));
   endproperty
   a_read_back: assert property (p_read_back) // [RULE12]
      else $error("read did not return the stored selection");

   property p_read_no_effect;
      @(posedge core_clk) disable iff (reset)
      (reg_rd && !reg_wr) |=> (select_r == $past(select_r));
   endproperty
   a_read_no_effect: assert property (p_read_no_effect) // [RULE12]
      else $error("read disturbed the selection register");

   property p_field_layout;
      @(posedge core_clk) disable iff (reset)
      (reg_wr && hit && reg_wdata[23:22] == edge_sel_none)
         |=> ##1 !edge_irq_event[11];
   endproperty
   a_field_layout: assert property (p_field_layout) // [RULE2]
      else $error("input 11 fired after its field was cleared");

   property p_group_low;
      @(posedge core_clk) disable iff (reset)
      1'b1 |=> (input_threshold_sel[7:0]
                == {4{$past(threshold_group_0_to_3)}});
   endproperty
   a_group_low: assert property (p_group_low) // [RULE9]
      else $error("inputs 0-3 not on their group threshold");

   property p_group_mid;
      @(posedge core_clk) disable iff (reset)
      1'b1 |=> (input_threshold_sel[15:8]
                == {4{$past(threshold_group_4_to_7)}});
   endproperty
   a_group_mid: assert property (p_group_mid) // [RULE8]
      else $error("inputs 4-7 not on their group threshold");

   property p_group_high;
      @(posedge core_clk) disable iff (reset)
      1'b1 |=> (input_threshold_sel[23:16]
                == {4{$past(threshold_group_8_to_11)}});
   endproperty
   a_group_high: assert property (p_group_high) // [RULE7]
      else $error("inputs 8-11 not on their group threshold");

   property p_retune_quiet;
      @(posedge core_clk) disable iff (reset)
      (threshold_group_0_to_3 != $past(threshold_group_0_to_3))
         |=> (edge_irq_event[3:0] == 4'h0);
   endproperty
   a_retune_quiet: assert property (p_retune_quiet) // [RULE10]
      else $error("event from a stale baseline after retune");

   property p_event_cause;
      @(posedge core_clk) disable iff (reset)
      (|edge_irq_event) |-> ((edge_irq_event & $past(sample_strobe))
                             == edge_irq_event);
   endproperty
   a_event_cause: assert property (p_event_cause) // [RULE11]
      else $error("event without a sample one cycle before");
endmodule : edge_irq_select_low

/* File: verification/host_model.sv */
// host_model: register-side master standing in for the serial host.
// assumes one core_clk domain and the one-cycle strobes of the block.
module host_model
(
   input wire logic core_clk, // core clock
   output logic [5:0] reg_addr, // register offset
   output logic reg_wr, // write strobe
   output logic [23:0] reg_wdata, // write data
   output logic reg_rd, // read strobe
   input wire logic [23:0] reg_rdata, // read data
   input wire logic reg_rvalid // read answer pulse
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus at time zero
   initial
   begin
      reg_addr = 6'h00;
      reg_wr = 1'b0;
      reg_wdata = 24'h000000;
      reg_rd = 1'b0;
   end

   // data inverted once released, so stale data never looks valid
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr

   // answer taken at the edge that sees reg_rvalid high
   task automatic rd(input logic [5:0] a, output logic [23:0] d,
      output logic ok);
      ok = 1'b0;
      d = 24'h000000;
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      for (int n = 0; n < 4 && ok == 1'b0; n++)
      begin
         @(posedge core_clk);
         if (reg_rvalid === 1'b1)
         begin
            d = reg_rdata;
            ok = 1'b1;
         end
      end
   endtask : rd
endmodule : host_model

/* File: verification/testbench.sv */
// testbench: self-checking bench for the low edge-selection block.
// assumes host_model for register traffic and a 200 MHz core clock.
module testbench
   import edge_irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [5:0] reg_addr;
   logic reg_wr;
   logic [23:0] reg_wdata;
   logic reg_rd;
   logic [23:0] reg_rdata;
   logic reg_rvalid;
   logic [1:0] threshold_group_0_to_3 = 2'h0;
   logic [1:0] threshold_group_4_to_7 = 2'h0;
   logic [1:0] threshold_group_8_to_11 = 2'h0;
   logic [11:0] sample_strobe = 12'h000;
   logic [11:0] comp_above = 12'h000;
   logic [23:0] input_threshold_sel;
   logic [11:0] edge_irq_event;
   logic [23:0] edge_irq_select_inputs_low;
   int n_mismatch = 0;
   int checks_done = 0;

   edge_irq_select_low i_edge_irq_select_low (
      .core_clk(core_clk),
      .reset(reset),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_wdata(reg_wdata),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid),
      .threshold_group_0_to_3(threshold_group_0_to_3),
      .threshold_group_4_to_7(threshold_group_4_to_7),
      .threshold_group_8_to_11(threshold_group_8_to_11),
      .sample_strobe(sample_strobe),
      .comp_above(comp_above),
      .input_threshold_sel(input_threshold_sel),
      .edge_irq_event(edge_irq_event),
      .edge_irq_select_inputs_low(edge_irq_select_inputs_low)
   );

   host_model i_host_model (
      .core_clk(core_clk),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_wdata(reg_wdata),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid)
   );

   // free-running core clock, 5 ns period
   initial
   begin
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // a read that never answers ends the run
   task automatic rd_check(input logic [5:0] a, input logic [23:0] exp);
      logic [23:0] d;
      logic ok;
      i_host_model.rd(a, d, ok);
      if (ok !== 1'b1)
      begin
         n_mismatch++;
         tally_and_finish();
      end
      else
      begin
         check(d, exp);
      end
   endtask : rd_check

   // strobe every input once; event judged one cycle after the take
   task automatic sample(input logic [11:0] a, input logic [11:0] exp);
      @(posedge core_clk);
      sample_strobe <= 12'hFFF;
      comp_above <= a;
      @(posedge core_clk);
      sample_strobe <= 12'h000;
      #1;
      check({12'h000, edge_irq_event}, {12'h000, exp});
   endtask : sample

   task automatic t_reset;
      check(edge_irq_select_inputs_low, 24'h000000);
      rd_check(select_low_offset, 24'h000000);
   endtask : t_reset

   // other offsets must neither write nor echo the register
   task automatic t_regs;
      i_host_model.wr(select_low_offset, 24'hC3A55A);
      // the copy updates at the write's edge, so look once it settled
      #1;
      check(edge_irq_select_inputs_low, 24'hC3A55A);
      rd_check(select_low_offset, 24'hC3A55A);
      i_host_model.wr(6'h21, 24'hFFFFFF);
      rd_check(6'h21, 24'h000000);
      rd_check(select_low_offset, 24'hC3A55A);
   endtask : t_regs

   // per group fields 3,2,1,0 on inputs 0..3 cover every code
   task automatic t_modes;
      i_host_model.wr(select_low_offset, 24'h1B1B1B);
      sample(12'h000, 12'h000);
      sample(12'hFFF, 12'h555);
      sample(12'h000, 12'h333);
   endtask : t_modes

   // a threshold change rebases only its own group
   task automatic t_groups;
      @(posedge core_clk);
      threshold_group_0_to_3 <= 2'h1;
      threshold_group_4_to_7 <= 2'h2;
      threshold_group_8_to_11 <= 2'h3;
      repeat (2) @(posedge core_clk);
      #1;
      check(input_threshold_sel, 24'hFFAA55);
      sample(12'h000, 12'h000);
      @(posedge core_clk);
      threshold_group_0_to_3 <= 2'h0;
      sample(12'hFFF, 12'h550);
      check(input_threshold_sel, 24'hFFAA00);
      sample(12'h000, 12'h333);
   endtask : t_groups

   // comparator moves without a strobe are ignored
   task automatic t_nostrobe;
      @(posedge core_clk);
      comp_above <= 12'hFFF;
      repeat (2) @(posedge core_clk);
      #1;
      check({12'h000, edge_irq_event}, 24'h000000);
   endtask : t_nostrobe

   // retune of group 4-7 in the sample's own cycle: that group only
   // takes the new baseline, the next fall proves it was taken
   task automatic t_retune_same;
      @(posedge core_clk);
      threshold_group_4_to_7 <= 2'h1;
      sample_strobe <= 12'hFFF;
      comp_above <= 12'hFFF;
      @(posedge core_clk);
      sample_strobe <= 12'h000;
      #1;
      check({12'h000, edge_irq_event}, 24'h000505);
      sample(12'h000, 12'h333);
   endtask : t_retune_same

   // main sequence after a 16-cycle reset
   initial
   begin
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_regs();
      t_modes();
      t_groups();
      t_nostrobe();
      t_retune_same();
      tally_and_finish();
   end
endmodule : testbench
